/* File: verilog/fhl_pkg.sv */
// package of the fault history log: register offsets, widths, reset values
// assumes a parameter-style register port addressed by 16-bit offset
package fhl_pkg;
  // ==========================================================
  // register offsets
  localparam logic [15:0] FHL_LAST_STOP_OFS    = 16'h1C0A;
  localparam logic [15:0] FHL_POWER_ON_OFS     = 16'h3B04;
  localparam logic [15:0] FHL_CLEAR_OFS        = 16'h3B08;
  localparam logic [15:0] FHL_REWIND_OFS       = 16'h3B0A;
  localparam logic [15:0] FHL_ERR_CODE_OFS     = 16'h3C02;
  localparam logic [15:0] FHL_ERR_CLASS_OFS    = 16'h3C04;
  localparam logic [15:0] FHL_ERR_TIME_OFS     = 16'h3C06;
  localparam logic [15:0] FHL_QUAL_OFS         = 16'h3C08;
  localparam logic [15:0] FHL_EN_CYC_OFS       = 16'h3C0A;
  localparam logic [15:0] FHL_EN_TIME_OFS      = 16'h3C0C;
  localparam logic [15:0] FHL_VBUS_OFS         = 16'h3C0E;
  localparam logic [15:0] FHL_VEL_OFS          = 16'h3C10;
  localparam logic [15:0] FHL_CUR_OFS          = 16'h3C12;
  localparam logic [15:0] FHL_TEMP_PA_OFS      = 16'h3C14;
  localparam logic [15:0] FHL_TEMP_DEV_OFS     = 16'h3C16;
  // ==========================================================
  // values and limits
  localparam int          FHL_DEPTH            = 10;
  localparam logic [15:0] FHL_CMD_ACTIVE       = 16'h0001;
  localparam logic [15:0] FHL_LAST_STOP_RST    = 16'h0000;
  localparam logic [15:0] FHL_END_MARK         = 16'h0000;
  localparam logic [2:0]  FHL_CLASS_MAX        = 3'h4;
  localparam logic [31:0] FHL_TIME_MAX         = 32'h1FFFFFFF;
  // ==========================================================
  // clear sequencer states
  typedef enum logic [1:0] {
    FHL_IDLE  = 2'b00,
    FHL_WIPE  = 2'b01
  } fhl_clr_state_t;
  // ==========================================================
  // one history entry
  typedef struct packed {
    logic [15:0] code;
    logic [2:0]  err_class;
    logic [31:0] err_time;
    logic [15:0] qual;
    logic [15:0] en_cycles;
    logic [15:0] en_time;
    logic [15:0] vbus;
    logic [15:0] velocity;
    logic [15:0] current;
    logic [15:0] temp_pa;
    logic [15:0] temp_dev;
  } fhl_entry_t;
endpackage

/* File: verilog/fhl_log.sv */
// fault history log: ten-entry error snapshot store with sequential reader
// assumes error events and live measurements come synchronous to core_clk;
// retention across power-off is provided by the storage technology, so the
// history array has no reset here
// ==========================================================
module fhl_log
  import fhl_pkg::*;
#(
  parameter int DEPTH = FHL_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        err_valid,
  input  wire logic [15:0] err_code,
  input  wire logic [2:0]  err_class,
  input  wire logic [15:0] err_qual,
  input  wire logic [31:0] op_seconds,
  input  wire logic [15:0] live_current,
  input  wire logic [15:0] live_vbus,
  input  wire logic [15:0] live_velocity,
  input  wire logic [15:0] live_temp_pa,
  input  wire logic [15:0] live_temp_dev,
  input  wire logic [31:0] power_on_count,
  input  wire logic        stage_enable,
  input  wire logic        ctrl_power_up,
  input  wire logic        sec_tick,
  input  wire logic        par_rd,
  input  wire logic        par_wr,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic [31:0]      par_rdata,
  output logic             par_ack,
  output logic             par_err
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH + 1);

  // ==========================================================
  // storage
  fhl_entry_t         hist_mem [DEPTH];
  fhl_entry_t         stage_r;
  logic [CW-1:0]      count_r;
  logic [PW-1:0]      rd_ptr_r;
  logic [15:0]        last_stop_r;
  logic [15:0]        en_cyc_r;
  logic [15:0]        en_time_r;
  logic               stage_en_d_r;
  fhl_clr_state_t     clr_state_r;
  logic [31:0]        rdata_nxt;
  logic               hit;
  fhl_entry_t         snap;

  // strobe and address are arguments so the nets follow every change
  function automatic logic addr_hit(input logic        stb,
                                    input logic [15:0] a,
                                    input logic [15:0] ofs);
    return stb && (a == ofs);
  endfunction

  wire logic code_rd   = addr_hit(par_rd, par_addr, FHL_ERR_CODE_OFS);
  wire logic clr_req   = addr_hit(par_wr, par_addr, FHL_CLEAR_OFS) &&
                         (par_wdata[15:0] == FHL_CMD_ACTIVE);
  wire logic rewind    = addr_hit(par_wr, par_addr, FHL_REWIND_OFS) &&
                         (par_wdata[15:0] == FHL_CMD_ACTIVE);
  wire logic entry_ok  = {1'b0, rd_ptr_r} < {1'b0, count_r};
  wire logic clearing  = (clr_state_r == FHL_WIPE);

  // ==========================================================
  // enable statistics
  // enable cycle count
  always_ff @(posedge core_clk) begin
    stage_en_d_r <= rst ? 1'b0 : stage_enable;
    if (rst || ctrl_power_up) begin
      en_cyc_r <= '0;
    end else if (stage_enable && !stage_en_d_r) begin
      en_cyc_r <= en_cyc_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || (stage_enable && !stage_en_d_r)) begin
      en_time_r <= '0;
    end else if (stage_enable && sec_tick && en_time_r != 16'hFFFF) begin
      en_time_r <= en_time_r + 16'h0001;
    end
  end

  // ==========================================================
  // snapshot of the live values at detection
  // capture at detection
  always_comb begin
    snap.code      = err_code;
    snap.err_class = (err_class > FHL_CLASS_MAX) ? FHL_CLASS_MAX : err_class;
    snap.err_time  = (op_seconds > FHL_TIME_MAX) ? FHL_TIME_MAX : op_seconds;
    snap.qual      = err_qual;
    snap.en_cycles = en_cyc_r;
    snap.en_time   = en_time_r;
    snap.vbus      = live_vbus;
    snap.velocity  = live_velocity;
    snap.current   = live_current;
    snap.temp_pa   = live_temp_pa;
    snap.temp_dev  = live_temp_dev;
  end

  // ==========================================================
  // history array, no reset so contents persist
  // ordered store
  always_ff @(posedge core_clk) begin
    if (err_valid && !clearing) begin
      if (count_r == CW'(DEPTH)) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          hist_mem[i] <= hist_mem[i+1];
        end
        hist_mem[DEPTH-1] <= snap;
      end else begin
        hist_mem[count_r] <= snap;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clr_state_r <= FHL_IDLE;
    end else begin
      case (clr_state_r)
        FHL_IDLE: begin
          if (clr_req) clr_state_r <= FHL_WIPE;
        end
        FHL_WIPE: begin
          clr_state_r <= FHL_IDLE;
        end
        default: clr_state_r <= FHL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (clearing) begin
      count_r <= '0;
    end else if (err_valid && count_r != CW'(DEPTH)) begin
      count_r <= count_r + CW'(1);
    end
  end

  // ==========================================================
  // read pointer and staging
  // pointer control
  always_ff @(posedge core_clk) begin
    if (rst || rewind || clearing) begin
      rd_ptr_r <= '0;
    end else if (code_rd && entry_ok) begin
      rd_ptr_r <= rd_ptr_r + PW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage_r <= '0;
    end else if (code_rd) begin
      stage_r <= entry_ok ? hist_mem[rd_ptr_r] : '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_stop_r <= FHL_LAST_STOP_RST;
    end else if (err_valid && err_class != 3'h0) begin
      last_stop_r <= err_code;
    end
  end

  // ==========================================================
  // register read port
  always_comb begin
    hit       = 1'b1;
    rdata_nxt = '0;
    if (par_addr == FHL_LAST_STOP_OFS) begin
      rdata_nxt = {16'h0000, last_stop_r};
    end else if (par_addr == FHL_POWER_ON_OFS) begin
      rdata_nxt = power_on_count;
    end else if (par_addr == FHL_CLEAR_OFS) begin
      rdata_nxt = {31'h0, clearing || clr_req};
    end else if (par_addr == FHL_REWIND_OFS) begin
      rdata_nxt = '0;
    end else if (par_addr == FHL_ERR_CODE_OFS) begin
      rdata_nxt = {16'h0000, entry_ok ? hist_mem[rd_ptr_r].code
                                      : FHL_END_MARK};
    end else if (par_addr == FHL_ERR_CLASS_OFS) begin
      rdata_nxt = {29'h0, stage_r.err_class};
    end else if (par_addr == FHL_ERR_TIME_OFS) begin
      rdata_nxt = stage_r.err_time;
    end else if (par_addr == FHL_QUAL_OFS) begin
      rdata_nxt = {16'h0000, stage_r.qual};
    end else if (par_addr == FHL_EN_CYC_OFS) begin
      rdata_nxt = {16'h0000, stage_r.en_cycles};
    end else if (par_addr == FHL_EN_TIME_OFS) begin
      rdata_nxt = {16'h0000, stage_r.en_time};
    end else if (par_addr == FHL_VBUS_OFS) begin
      rdata_nxt = {16'h0000, stage_r.vbus};
    end else if (par_addr == FHL_VEL_OFS) begin
      rdata_nxt = {{16{stage_r.velocity[15]}}, stage_r.velocity};
    end else if (par_addr == FHL_CUR_OFS) begin
      rdata_nxt = {16'h0000, stage_r.current};
    end else if (par_addr == FHL_TEMP_PA_OFS) begin
      rdata_nxt = {{16{stage_r.temp_pa[15]}}, stage_r.temp_pa};
    end else if (par_addr == FHL_TEMP_DEV_OFS) begin
      rdata_nxt = {{16{stage_r.temp_dev[15]}}, stage_r.temp_dev};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      par_rdata <= '0;
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
    end else begin
      par_rdata <= par_rd ? rdata_nxt : 32'h0;
      par_ack   <= (par_rd || par_wr) && hit;
      par_err   <= (par_rd || par_wr) && !hit;
    end
  end

  // ==========================================================
  // checks
  sequence code_read_s;
    code_rd && entry_ok && !rewind && !clearing;
  endsequence

  sequence store_new_s;
    err_valid && !clearing && count_r < CW'(DEPTH);
  endsequence

  sequence store_full_s;
    err_valid && !clearing && count_r == CW'(DEPTH);
  endsequence

  sequence stage_rise_s;
    stage_enable && !stage_en_d_r;
  endsequence

  advance_ptr_a: assert property (@(posedge core_clk) disable iff (rst)
    code_read_s |=> rd_ptr_r == $past(rd_ptr_r) + PW'(1))
    else $error("pointer did not advance");

  rewind_ptr_a: assert property (@(posedge core_clk) disable iff (rst)
    rewind |=> rd_ptr_r == '0)
    else $error("rewind did not reach oldest");

  end_mark_a: assert property (@(posedge core_clk) disable iff (rst)
    code_rd && !entry_ok |=> par_rdata == 32'h0)
    else $error("end marker not zero");

  stage_copy_a: assert property (@(posedge core_clk) disable iff (rst)
    code_read_s |=> stage_r.code == par_rdata[15:0])
    else $error("staging differs from code read");

  clear_done_a: assert property (@(posedge core_clk) disable iff (rst)
    clr_req && !clearing |=> clearing ##1 (count_r == '0))
    else $error("clear did not empty log");

  // count is unknown until the first clear; only a known overflow fails
  count_cap_a: assert property (@(posedge core_clk) disable iff (rst)
    not (count_r > CW'(DEPTH)))
    else $error("more than ten entries");

  class_range_a: assert property (@(posedge core_clk) disable iff (rst)
    stage_r.err_class <= FHL_CLASS_MAX)
    else $error("class out of range");

  time_range_a: assert property (@(posedge core_clk) disable iff (rst)
    stage_r.err_time <= FHL_TIME_MAX)
    else $error("time beyond limit");

  stop_code_a: assert property (@(posedge core_clk) disable iff (rst)
    err_valid && err_class != 3'h0 |=> last_stop_r == $past(err_code))
    else $error("stop code not latched");

  stop_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    err_valid && err_class == 3'h0 |=> $stable(last_stop_r))
    else $error("class 0 changed stop code");

  count_step_a: assert property (@(posedge core_clk) disable iff (rst)
    store_new_s |=> count_r == $past(count_r) + CW'(1))
    else $error("entry count did not grow");

  store_slot_a: assert property (@(posedge core_clk) disable iff (rst)
    store_new_s |=> hist_mem[$past(count_r)] == $past(snap))
    else $error("entry not stored after the newest");

  drop_oldest_a: assert property (@(posedge core_clk) disable iff (rst)
    store_full_s |=> hist_mem[DEPTH-1] == $past(snap) &&
                     hist_mem[0] == $past(hist_mem[1]))
    else $error("oldest entry not dropped");

  end_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    code_rd && !entry_ok && !clearing |=> $stable(rd_ptr_r))
    else $error("pointer moved past the end");

  enable_count_a: assert property (@(posedge core_clk) disable iff (rst)
    stage_rise_s ##0 !ctrl_power_up |=>
      en_cyc_r == $past(en_cyc_r) + 16'h0001)
    else $error("enable cycle not counted");

  enable_time_a: assert property (@(posedge core_clk) disable iff (rst)
    stage_rise_s |=> en_time_r == 16'h0000)
    else $error("enable time not restarted");

  qual_read_a: assert property (@(posedge core_clk) disable iff (rst)
    par_rd && par_addr == FHL_QUAL_OFS |=>
      par_rdata == {16'h0000, $past(stage_r.qual)})
    else $error("qualifier not read from staging");

  write_answer_a: assert property (@(posedge core_clk) disable iff (rst)
    par_wr |=> par_ack != par_err)
    else $error("write not answered once");
endmodule

/* File: testbench/fhl_master.sv */
// fieldbus master model: parameter reads and writes, log clear
// assumes the port takes a one-cycle strobe and answers one cycle later
module fhl_master
  import fhl_pkg::*;
(
  input  wire logic        core_clk,
  output logic             par_rd,
  output logic             par_wr,
  output logic [15:0]      par_addr,
  output logic [31:0]      par_wdata,
  input  wire logic [31:0] par_rdata,
  input  wire logic        par_ack,
  input  wire logic        par_err
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    par_rd    = 1'b0;
    par_wr    = 1'b0;
    par_addr  = 16'h0000;
    par_wdata = 32'h0;
  end
  // released address and data lines show the inverse, never the last value; both strobes drop to 0
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic [1:0] rsp);
    @(posedge core_clk);
    par_rd    <= !wr;
    par_wr    <= wr;
    par_addr  <= a;
    par_wdata <= d;
    @(posedge core_clk);
    par_rd    <= 1'b0;
    par_wr    <= 1'b0;
    par_addr  <= ~a;
    par_wdata <= ~d;
    // answer is registered: take it at the edge where it is sampled
    @(posedge core_clk);
    q   = par_rdata;
    rsp = {par_err, par_ack};
  endtask
  task automatic clear_log(output logic ok);
    logic [31:0] q;
    logic [1:0]  r;
    access(1'b1, FHL_CLEAR_OFS, 32'h1, q, r);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      access(1'b0, FHL_CLEAR_OFS, 32'h0, q, r);
      ok = (q === 32'h0);
    end
  endtask
endmodule

/* File: testbench/fault_history_log_test.sv */
// self-checking bench of the fault history log
// assumes fhl_master drives the parameter port; one clock, sync reset
module fault_history_log_test
  import fhl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst, err_valid, stage_enable, ctrl_power_up;
  logic        sec_tick, par_rd, par_wr, par_ack, par_err, ok;
  logic [2:0]  err_class;
  logic [15:0] err_code, err_qual, par_addr, live_current, live_vbus;
  logic [15:0] live_velocity, live_temp_pa, live_temp_dev;
  logic [31:0] op_seconds, power_on_count, par_wdata, par_rdata;
  int          err_total, checked, cycles;

  fhl_log #(.DEPTH(FHL_DEPTH)) fhl_log_inst (
    .core_clk, .rst, .err_valid, .err_code, .err_class, .err_qual,
    .op_seconds, .live_current, .live_vbus, .live_velocity,
    .live_temp_pa, .live_temp_dev, .power_on_count, .stage_enable,
    .ctrl_power_up, .sec_tick, .par_rd, .par_wr, .par_addr, .par_wdata,
    .par_rdata, .par_ack, .par_err);
  fhl_master fhl_master_inst (
    .core_clk, .par_rd, .par_wr, .par_addr, .par_wdata, .par_rdata,
    .par_ack, .par_err);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================
  // checks and bus helpers
  task automatic chk_data(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic [1:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: response %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic [1:0]  r;
    fhl_master_inst.access(1'b0, a, 32'h0, q, r);
    chk_flag(r, 2'b01);
    chk_data(q, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    fhl_master_inst.access(1'b1, a, d, q, r);
    chk_flag(r, 2'b01);
  endtask
  task automatic inject(input logic [15:0] c, input logic [2:0] k,
                        input logic [31:0] t);
    @(posedge core_clk);
    err_valid     <= 1'b1;
    err_code      <= c;
    err_class     <= k;
    err_qual      <= ~c;
    op_seconds    <= t;
    live_current  <= c + 16'h0100;
    live_vbus     <= c + 16'h0200;
    live_velocity <= c | 16'h8000;
    live_temp_pa  <= c;
    live_temp_dev <= c | 16'hC000;
    @(posedge core_clk);
    err_valid     <= 1'b0;
    op_seconds    <= 32'h0;
    {live_current, live_vbus, live_velocity} <= '1;
    {live_temp_pa, live_temp_dev} <= '1;
  endtask
  task automatic check_entry(input logic [15:0] c, input logic [2:0] k,
                             input logic [31:0] t);
    rd(FHL_ERR_CODE_OFS, {16'h0000, c});
    rd(FHL_ERR_CLASS_OFS, k > 3'h4 ? 32'h4 : {29'h0, k});
    rd(FHL_ERR_TIME_OFS, t > FHL_TIME_MAX ? FHL_TIME_MAX : t);
    rd(FHL_QUAL_OFS, {16'h0000, ~c});
    rd(FHL_EN_CYC_OFS, 32'h2);
    rd(FHL_EN_TIME_OFS, 32'h3);
    rd(FHL_VBUS_OFS, {16'h0000, c + 16'h0200});
    rd(FHL_VEL_OFS, {16'hFFFF, c | 16'h8000});
    rd(FHL_CUR_OFS, {16'h0000, c + 16'h0100});
    rd(FHL_TEMP_PA_OFS, {16'h0000, c});
    rd(FHL_TEMP_DEV_OFS, {16'hFFFF, c | 16'hC000});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] q;
    logic [1:0]  r;
    fhl_master_inst.clear_log(ok);
    chk_flag({1'b0, ok}, 2'b01);
    rd(FHL_LAST_STOP_OFS, 32'h0);
    rd(FHL_POWER_ON_OFS, 32'hFFFFFFFF);
    rd(FHL_REWIND_OFS, 32'h0);
    rd(FHL_ERR_CODE_OFS, 32'h0);
    wr(FHL_ERR_CODE_OFS, 32'h5);
    fhl_master_inst.access(1'b0, 16'h3C18, 32'h0, q, r);
    chk_flag(r, 2'b10);
    $display("test regs done");
  endtask
  task automatic t_entries;
    @(posedge core_clk) ctrl_power_up <= 1'b1;
    @(posedge core_clk) ctrl_power_up <= 1'b0;
    repeat (2) begin
      @(posedge core_clk) stage_enable <= 1'b0;
      @(posedge core_clk) stage_enable <= 1'b1;
    end
    repeat (3) begin
      @(posedge core_clk) sec_tick <= 1'b1;
      @(posedge core_clk) sec_tick <= 1'b0;
    end
    inject(16'h0001, 3'h0, 32'h10);
    rd(FHL_LAST_STOP_OFS, 32'h0);
    inject(16'h0002, 3'h2, 32'hFFFFFFFF);
    inject(16'h0003, 3'h7, 32'h1FFFFFFF);
    rd(FHL_LAST_STOP_OFS, 32'h3);
    wr(FHL_REWIND_OFS, 32'h1);
    check_entry(16'h0001, 3'h0, 32'h10);
    wr(FHL_REWIND_OFS, 32'h2);
    check_entry(16'h0002, 3'h2, 32'hFFFFFFFF);
    check_entry(16'h0003, 3'h7, 32'h1FFFFFFF);
    rd(FHL_ERR_CODE_OFS, 32'h0);
    rd(FHL_ERR_CODE_OFS, 32'h0);
    wr(FHL_REWIND_OFS, 32'h1);
    rd(FHL_ERR_CODE_OFS, 32'h1);
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(FHL_LAST_STOP_OFS, 32'h0);
    rd(FHL_ERR_CODE_OFS, 32'h1);
    $display("test entries done");
  endtask
  task automatic t_overflow;
    fhl_master_inst.clear_log(ok);
    chk_flag({1'b0, ok}, 2'b01);
    for (int i = 0; i < 11; i++) inject(16'h0010 + 16'(i), 3'h1, 32'h20);
    wr(FHL_REWIND_OFS, 32'h1);
    for (int i = 1; i < 11; i++) rd(FHL_ERR_CODE_OFS, 32'h10 + i);
    rd(FHL_ERR_CODE_OFS, 32'h0);
    $display("test overflow done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      give_verdict;
    end
  end
  initial begin
    {rst, err_valid, stage_enable, ctrl_power_up, sec_tick} = 5'b10000;
    {err_class, err_code, err_qual, op_seconds} = '0;
    {live_current, live_vbus, live_velocity} = '0;
    {live_temp_pa, live_temp_dev} = '0;
    power_on_count = 32'hFFFFFFFF;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_entries;
    t_overflow;
    give_verdict;
  end
endmodule
